// *** src/mbbi_bank.v ***
// bank translation and chip select decode, combinational
// assumes a 16-bit processor address and the bank register value
`timescale 1ns/1ps
`include "mbbi_map.vh"
module mbbi_bank (
    input wire [15:0] cpu_addr,
    input wire [4:0] bank_sel,
    input wire sleep_gate,
    output reg [3:0] ext_top,
    output reg use_secondary,
    output reg block_program
);
    always @*
    begin
        if (cpu_addr[15:14] == `MBBI_BANKED_TOP)
        begin
            ext_top = bank_sel[3:0];
            use_secondary = bank_sel[`MBBI_BANK_CS_BIT];
        end
        else
        begin
            ext_top = {`MBBI_ROOT_TOP, cpu_addr[15:14]};
            use_secondary = 1'b0;
        end
        block_program = sleep_gate && (cpu_addr == `MBBI_SLEEP_ADDR);
    end
endmodule

// *** src/mbbi_map.vh ***
// constants for the banked memory bus interface
// assumes inclusion by bare name from the design files
`ifndef MBBI_MAP_VH
`define MBBI_MAP_VH
`define MBBI_REG_BANK 4'h0
`define MBBI_REG_CTRL 4'h1
`define MBBI_REG_STAT 4'h2
`define MBBI_BANK_RST 5'h00
`define MBBI_BANK_CS_BIT 4
`define MBBI_CTRL_SLEEP_BIT 0
`define MBBI_CTRL_RST 1'b0
`define MBBI_BANKED_TOP 2'b10
`define MBBI_ROOT_TOP 2'b11
`define MBBI_SLEEP_ADDR 16'hffff
`endif

// *** src/mbbi_sync.v ***
// two flip-flop synchroniser, one instance covers all W bits
// assumes inputs come from pins outside sys_clk domain
`timescale 1ns/1ps
module mbbi_sync #(
    parameter W = 1
) (
    input wire sys_clk,
    input wire arst_n,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_q;
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q <= {W{1'b0}};
            q <= {W{1'b0}};
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// *** src/mbbi_top.v ***
// external parallel memory bus interface with bank extension
// assumes core bus signals on sys_clk; emulator pins asynchronous
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "mbbi_map.vh"
module mbbi_top (
    input wire sys_clk,
    input wire arst_n,
    input wire emulation_select,
    input wire core_valid,
    input wire core_rnw,
    input wire [15:0] core_addr,
    input wire [7:0] core_wdata,
    output reg [7:0] core_rdata,
    output reg [15:0] int_addr,
    output reg int_rnw,
    output reg [7:0] int_wdata,
    output reg int_valid,
    input wire [7:0] int_rdata,
    input wire address_latch_strobe,
    input wire [1:0] emulation_select_addr_hi,
    input wire [13:8] addr_hi_in,
    output reg [13:8] addr_hi_out,
    output reg addr_hi_oe,
    output reg [7:0] addr_lo,
    output reg [3:0] banked_addr,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg data_oe,
    input wire rnw_in,
    output reg rnw_out,
    output reg rnw_oe,
    output reg program_memory_select_n,
    output reg secondary_memory_select_n,
    output reg read_strobe_n,
    output reg write_strobe_n,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata
);
    wire emulation_select_s;
    wire as_s;
    wire rnw_s;
    wire [1:0] ahi2_s;
    wire [5:0] ahi_s;
    wire [7:0] d_s;
    reg [4:0] bank_q;
    reg sleep_q;
    reg [7:0] lat_q;
    reg emulation_select_p_q;
    wire [7:0] lo_addr;
    wire [15:0] bus_addr;
    wire bus_rnw;
    wire bus_valid;
    wire [3:0] top;
    wire sec;
    wire blk;
    reg [7:0] addr_lo_d;
    reg [5:0] addr_hi_d;
    reg [3:0] banked_d;
    reg [7:0] data_out_d;
    reg data_oe_d;
    reg drive_oe_d;
    reg rnw_out_d;
    reg prog_sel_n_d;
    reg sec_sel_n_d;
    reg rd_n_d;
    reg wr_n_d;
    reg [7:0] int_wdata_d;
    reg int_valid_d;
    reg [4:0] bank_d;
    reg sleep_d;
    reg [7:0] rdata_d;
    wire bank_wr;
    wire ctrl_wr;

    mbbi_sync #(.W(19)) u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .d({emulation_select, address_latch_strobe, rnw_in, emulation_select_addr_hi, addr_hi_in,
            data_in}),
        .q({emulation_select_s, as_s, rnw_s, ahi2_s, ahi_s, d_s})
    );

    // transparent address latch, enable follows the strobe
    assign lo_addr = as_s ? d_s : lat_q;
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            lat_q <= 8'h00;
        else if (as_s)
            lat_q <= d_s;
    end

    // internal bus source chosen by mode
    assign bus_addr = emulation_select_s ? {ahi2_s, ahi_s, lo_addr} : core_addr;
    assign bus_rnw = emulation_select_s ? rnw_s : core_rnw;
    assign bus_valid = emulation_select_s ? ~as_s : core_valid;

    mbbi_bank u_bank (
        .cpu_addr(bus_addr),
        .bank_sel(bank_q),
        .sleep_gate(sleep_q),
        .ext_top(top),
        .use_secondary(sec),
        .block_program(blk)
    );

    // register port decode
    assign bank_wr = reg_wr && (reg_addr == `MBBI_REG_BANK);
    assign ctrl_wr = reg_wr && (reg_addr == `MBBI_REG_CTRL);

    // bank register is write-only, its offset reads as zero
    always @*
    begin
        bank_d = bank_q;
        sleep_d = sleep_q;
        rdata_d = 8'h00;
        if (bank_wr)
            bank_d = reg_wdata[4:0];
        if (ctrl_wr)
            sleep_d = reg_wdata[`MBBI_CTRL_SLEEP_BIT];
        if (reg_rd)
        begin
            case (reg_addr)
                `MBBI_REG_CTRL: rdata_d = {7'h00, sleep_q};
                `MBBI_REG_STAT: rdata_d = {7'h00, emulation_select_s};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // bank and control registers
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bank_q <= `MBBI_BANK_RST;
            sleep_q <= `MBBI_CTRL_RST;
        end
        else
        begin
            bank_q <= bank_d;
            sleep_q <= sleep_d;
        end
    end

    // read data stand for one cycle after the read strobe
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rdata_d;
    end

    // next values for pins and internal bus
    always @*
    begin
        addr_lo_d = bus_addr[7:0];
        addr_hi_d = bus_addr[13:8];
        banked_d = top;
        drive_oe_d = ~emulation_select_s;
        rnw_out_d = core_rnw;
        data_out_d = core_wdata;
        data_oe_d = 1'b0;
        int_wdata_d = core_wdata;
        if (emulation_select_s)
        begin
            data_out_d = int_rdata;
            int_wdata_d = d_s;
        end
        else
            data_oe_d = core_valid && !core_rnw;
        prog_sel_n_d = ~(bus_valid && !sec && !blk);
        sec_sel_n_d = ~(bus_valid && sec);
        rd_n_d = ~(bus_valid && bus_rnw);
        wr_n_d = ~(bus_valid && !bus_rnw);
        int_valid_d = bus_valid && (emulation_select_s == emulation_select_p_q);
    end

    // address pins
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            addr_lo <= 8'h00;
            addr_hi_out <= 6'h00;
            addr_hi_oe <= 1'b0;
            banked_addr <= 4'h0;
        end
        else
        begin
            addr_lo <= addr_lo_d;
            addr_hi_out <= addr_hi_d;
            addr_hi_oe <= drive_oe_d;
            banked_addr <= banked_d;
        end
    end

    // data pins, driven only on normal-mode writes
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end
        else
        begin
            data_out <= data_out_d;
            data_oe <= data_oe_d;
        end
    end

    // read-not-write pin
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rnw_out <= 1'b1;
            rnw_oe <= 1'b0;
        end
        else
        begin
            rnw_out <= rnw_out_d;
            rnw_oe <= drive_oe_d;
        end
    end

    // chip selects
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            program_memory_select_n <= 1'b1;
            secondary_memory_select_n <= 1'b1;
        end
        else
        begin
            program_memory_select_n <= prog_sel_n_d;
            secondary_memory_select_n <= sec_sel_n_d;
        end
    end

    // read and write strobes
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
        end
        else
        begin
            read_strobe_n <= rd_n_d;
            write_strobe_n <= wr_n_d;
        end
    end

    // core read data taken from the data pins
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            core_rdata <= 8'h00;
        else
            core_rdata <= data_in;
    end

    // internal bus address and direction
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            int_addr <= 16'h0000;
            int_rnw <= 1'b1;
        end
        else
        begin
            int_addr <= bus_addr;
            int_rnw <= bus_rnw;
        end
    end

    // internal bus data and valid, valid held off while the mode changes
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            int_wdata <= 8'h00;
            int_valid <= 1'b0;
        end
        else
        begin
            int_wdata <= int_wdata_d;
            int_valid <= int_valid_d;
        end
    end

    // previous mode, for the mode-change guard
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            emulation_select_p_q <= 1'b0;
        else
            emulation_select_p_q <= emulation_select_s;
    end
endmodule

// *** tb/mbbi_mem.sv ***
// external memory model on the parallel bus
// assumes active-low selects and strobes
`timescale 1ns/1ps
module mbbi_mem (
    input wire logic sys_clk,
    input wire logic program_memory_select_n,
    input wire logic secondary_memory_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] addr_lo,
    input wire logic [7:0] data_out,
    output logic [7:0] data_in
);
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    wire sel = !(program_memory_select_n && secondary_memory_select_n);
    always @(posedge sys_clk)
        if (sel && !write_strobe_n)
            mem[addr_lo] <= data_out;
    always @(posedge sys_clk)
        if (sel && !read_strobe_n)
            last <= mem[addr_lo];
    // released bus shows the inverse of the last value
    assign data_in = (sel && !read_strobe_n) ? mem[addr_lo] : ~last;
endmodule

// *** tb/mbbi_top_assertions.sv ***
// port checks for the bus interface top
// assumes bound into every mbbi_top
`timescale 1ns/1ps
module mbbi_assertions (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic core_valid,
    input wire logic [15:0] core_addr,
    input wire logic [7:0] addr_lo,
    input wire logic [13:8] addr_hi_out,
    input wire logic addr_hi_oe,
    input wire logic [3:0] banked_addr,
    input wire logic data_oe,
    input wire logic program_memory_select_n,
    input wire logic secondary_memory_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic v_q;
    always_ff @(posedge sys_clk or negedge arst_n)
        if (!arst_n)
            v_q <= 1'b0;
        else
            v_q <= core_valid && addr_hi_oe;
    lo_addr_a: assert property (v_q |-> addr_lo == $past(core_addr[7:0]))
        else $error("low address");
    hi_addr_a: assert property (v_q |-> addr_hi_out == $past(core_addr[13:8]))
        else $error("mid address");
    root_top_a: assert property (v_q && $past(core_addr[15:14]) != 2'b10
        |-> banked_addr == {2'b11, $past(core_addr[15:14])}) else $error("root top");
    root_sec_a: assert property (v_q && $past(core_addr[15:14]) != 2'b10
        |-> secondary_memory_select_n) else $error("root secondary");
    one_sel_a: assert property (v_q && $past(core_addr) != 16'hffff
        |-> program_memory_select_n != secondary_memory_select_n) else $error("select");
    acc_strobe_a: assert property (v_q && $past(core_addr) != 16'hffff
        |-> read_strobe_n != write_strobe_n) else $error("strobe");
    strobe_excl_a: assert property (read_strobe_n || write_strobe_n)
        else $error("both strobes");
    data_dir_a: assert property (data_oe |-> !write_strobe_n)
        else $error("data drive");
    cover property (v_q && !secondary_memory_select_n);
    cover property (data_oe);
    cover property ($fell(addr_hi_oe));
endmodule
bind mbbi_top mbbi_assertions chk (.*);

// *** tb/mbbi_top_test.sv ***
// bench for the banked memory bus interface
// assumes the memory model and the bound checker
`timescale 1ns/1ps
module mbbi_top_test;
    logic sys_clk = 1'b0, arst_n = 1'b0, emulation_select = 1'b0, core_valid = 1'b0;
    logic core_rnw = 1'b1, address_latch_strobe = 1'b0, rnw_in = 1'b1, reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] core_addr = 16'h0;
    logic [7:0] core_wdata = 8'h0, int_rdata = 8'h3c, reg_wdata = 8'h0;
    logic [1:0] emulation_select_addr_hi = 2'h0;
    logic [13:8] addr_hi_in = 6'h0;
    logic [3:0] reg_addr = 4'h0;
    wire [7:0] core_rdata, int_wdata, addr_lo, data_in, data_out, reg_rdata;
    wire [15:0] int_addr;
    wire [13:8] addr_hi_out;
    wire [3:0] banked_addr;
    wire int_rnw, int_valid, addr_hi_oe, data_oe, rnw_out, rnw_oe, read_strobe_n;
    wire program_memory_select_n, secondary_memory_select_n, write_strobe_n;
    wire [7:0] mem_d;
    logic [7:0] host_d = 8'h00;
    int mismatches = 0, check_count = 0;
    logic [31:0] rows [7] = '{32'h18001fc4, 32'h80000004, 32'hbfff1ff8, 32'h81231558,
        32'hc00013f4, 32'ha000e334, 32'h7fff09d4};
    always #5 sys_clk = ~sys_clk;
    mbbi_top uut (.*);
    mbbi_mem mem (.*, .data_in(mem_d));
    assign data_in = emulation_select ? host_d : mem_d;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task pins(input logic [3:0] t, input logic [1:0] s);
        chk({4'h0, banked_addr}, {4'h0, t});
        chk({6'h0, program_memory_select_n, secondary_memory_select_n}, {6'h0, s});
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task acc(input logic [15:0] a, input logic w, input logic [7:0] d);
        @(posedge sys_clk);
        core_valid <= 1'b1;
        core_rnw <= ~w;
        core_addr <= a;
        core_wdata <= d;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task end_of_test;
        if (mismatches == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #100000;
        mismatches++;
        end_of_test;
    end
    initial
    begin
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        #1 chk({7'h0, program_memory_select_n}, 8'h01);
        acc(16'h9000, 1'b0, 8'h00);
        pins(4'h0, 2'b01);
        foreach (rows[i])
        begin
            wr(4'h0, rows[i][15:8]);
            acc(rows[i][31:16], 1'b0, 8'h00);
            pins(rows[i][7:4], rows[i][3:2]);
        end
        wr(4'h1, 8'h01);
        acc(16'hffff, 1'b0, 8'h00);
        pins(4'hf, 2'b11);
        acc(16'h1234, 1'b1, 8'ha5);
        chk({7'h0, write_strobe_n}, 8'h00);
        acc(16'h1234, 1'b0, 8'h00);
        chk(core_rdata, 8'ha5);
        rd(4'h0, 8'h00);
        rd(4'hf, 8'h00);
        rd(4'h1, 8'h01);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        acc(16'h9000, 1'b0, 8'h00);
        pins(4'h0, 2'b01);
        rd(4'h1, 8'h00);
        wr(4'h0, 8'h1a);
        @(posedge sys_clk);
        core_valid <= 1'b0;
        emulation_select <= 1'b1;
        repeat (5) @(posedge sys_clk);
        #1 chk({6'h0, addr_hi_oe, rnw_oe}, 8'h00);
        @(posedge sys_clk);
        address_latch_strobe <= 1'b1;
        host_d <= 8'h56;
        emulation_select_addr_hi <= 2'h2;
        addr_hi_in <= 6'h12;
        rnw_in <= 1'b0;
        repeat (2) @(posedge sys_clk);
        address_latch_strobe <= 1'b0;
        host_d <= 8'h99;
        repeat (4) @(posedge sys_clk);
        #1 pins(4'ha, 2'b10);
        chk(addr_lo, 8'h56);
        chk(int_addr[15:8], 8'h92);
        chk(int_addr[7:0], 8'h56);
        chk(int_wdata, 8'h99);
        chk({6'h0, int_rnw, write_strobe_n}, 8'h00);
        chk({7'h0, int_valid}, 8'h01);
        end_of_test;
    end
endmodule
